/* rtl/ser_irq_pkg.sv */
/*
  Shared constants for the dual-channel serial interrupt and status block:
  register pointers, command codes, field positions and vector codes.
  Assumes a byte-wide host bus and channel index 0 = first, 1 = second.
*/
package ser_irq_pkg;
  // ------------------------------------------------------------------
  // Channels and widths
  // ------------------------------------------------------------------
  localparam int          NUM_CH  = 2;
  localparam int          CH_A    = 0;
  localparam int          CH_B    = 1;
  localparam int          PTR_W   = 3;
  localparam int          IDX_W   = 2;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [2:0]  RST_PINS = 3'h0;

  // ------------------------------------------------------------------
  // Register pointers (written into the command register)
  // ------------------------------------------------------------------
  localparam logic [PTR_W-1:0] REG_CMD = 3'h0;  // Command / line status
  localparam logic [PTR_W-1:0] REG_CFG = 3'h1;  // Interrupt config / receive error
  localparam logic [PTR_W-1:0] REG_VEC = 3'h2;  // Vector base / vector readback

  // ------------------------------------------------------------------
  // Command field of the command register
  // ------------------------------------------------------------------
  localparam int         CMD_MSB      = 5;
  localparam int         CMD_LSB      = 3;
  localparam logic [2:0] CMD_RST_EXT  = 3'h2;
  localparam logic [2:0] CMD_CHAN_RST = 3'h3;
  localparam logic [2:0] CMD_RST_TXP  = 3'h5;
  localparam logic [2:0] CMD_ERR_RST  = 3'h6;

  // ------------------------------------------------------------------
  // Interrupt configuration fields
  // ------------------------------------------------------------------
  localparam int         CFG_EXT_EN    = 0;
  localparam int         CFG_TX_EN     = 1;
  localparam int         CFG_SAV       = 2;
  localparam int         CFG_RXM_LSB   = 3;
  localparam int         CFG_RXM_MSB   = 4;
  localparam logic [1:0] RXM_OFF       = 2'h0;
  localparam logic [1:0] RXM_PAR_QUIET = 2'h3;  // Parity latched only

  // ------------------------------------------------------------------
  // Status register bit positions
  // ------------------------------------------------------------------
  localparam int LS_RXAV = 0;
  localparam int LS_TXE  = 2;
  localparam int LS_DCD  = 3;
  localparam int LS_CTS  = 5;
  localparam int LS_BRK  = 7;
  localparam int RE_PAR  = 4;
  localparam int RE_OVR  = 5;
  localparam int RE_FRM  = 6;

  // ------------------------------------------------------------------
  // Vector codes for bits 3..1, per channel and source
  // ------------------------------------------------------------------
  localparam int         VEC_LSB   = 1;
  localparam int         VEC_MSB   = 3;
  localparam logic [2:0] VA_SRX    = 3'h7;
  localparam logic [2:0] VA_RX     = 3'h6;
  localparam logic [2:0] VA_TX     = 3'h4;
  localparam logic [2:0] VA_EXT    = 3'h5;
  localparam logic [2:0] VB_SRX    = 3'h3;
  localparam logic [2:0] VB_RX     = 3'h2;
  localparam logic [2:0] VB_TX     = 3'h0;
  localparam logic [2:0] VB_EXT    = 3'h1;

  // ------------------------------------------------------------------
  // Receive holding buffer
  // ------------------------------------------------------------------
  localparam logic [IDX_W-1:0] RX_FULL = 2'h3;  // Three bytes
  localparam logic [IDX_W-1:0] RX_LAST = 2'h2;  // Highest slot index
  localparam logic [IDX_W-1:0] IDX_ONE = 2'h1;
  localparam logic [IDX_W-1:0] IDX_ZERO = 2'h0;
endpackage : ser_irq_pkg

/* rtl/rxq_if.sv */
/*
  Carrier between the controller and one receive holding buffer.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
interface rxq_if;
  logic       push;
  logic [7:0] push_data;
  logic       push_frm;
  logic       push_par;
  logic       pop;
  logic       flush;
  logic [7:0] head_data;
  logic       head_frm;
  logic       head_par;
  logic       not_empty;
  logic       overrun;

  modport owner  (output push, push_data, push_frm, push_par, pop, flush,
                  input  head_data, head_frm, head_par, not_empty, overrun);
  modport buffer (input  push, push_data, push_frm, push_par, pop, flush,
                  output head_data, head_frm, head_par, not_empty, overrun);
endinterface : rxq_if

/* rtl/rx_hold_buffer.sv */
/*
  Three-entry receive holding buffer with per-character error tags.
  Pops while empty are ignored; a push into a full buffer with no
  same-cycle pop overwrites the newest entry and pulses overrun.
*/
module rx_hold_buffer (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Owner side
  rxq_if.buffer    q
);
  import ser_irq_pkg::*;

  logic [9:0]       mem_ff [3];
  logic [IDX_W-1:0] rd_ff;
  logic [IDX_W-1:0] wr_ff;
  logic [IDX_W-1:0] cnt_ff;
  logic             ovr_ff;
  logic             full;
  logic             do_pop;

  // Wrap an index over the three slots
  function automatic logic [IDX_W-1:0] step(input logic [IDX_W-1:0] i);
    step = (i == RX_LAST) ? IDX_ZERO : i + IDX_ONE;
  endfunction : step

  function automatic logic [IDX_W-1:0] back(input logic [IDX_W-1:0] i);
    back = (i == IDX_ZERO) ? RX_LAST : i - IDX_ONE;
  endfunction : back

  assign full   = (cnt_ff == RX_FULL);
  assign do_pop = q.pop && (cnt_ff != IDX_ZERO);

  // Storage; when full and not draining, the newest slot is replaced
  always_ff @(posedge clock_i) begin
    if (q.push) begin
      if (full && !do_pop) begin
        mem_ff[back(wr_ff)] <= {q.push_frm, q.push_par, q.push_data};
      end else begin
        mem_ff[wr_ff] <= {q.push_frm, q.push_par, q.push_data};
      end
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clock_i) begin
    if (!rstn_i || q.flush) begin
      rd_ff  <= IDX_ZERO;
      wr_ff  <= IDX_ZERO;
      cnt_ff <= IDX_ZERO;
    end else begin
      if (do_pop) begin
        rd_ff <= step(rd_ff);
      end
      if (q.push && (!full || do_pop)) begin
        wr_ff <= step(wr_ff);
      end
      if (q.push && !full && !do_pop) begin
        cnt_ff <= cnt_ff + IDX_ONE;
      end else if (do_pop && !q.push) begin
        cnt_ff <= cnt_ff - IDX_ONE;
      end
    end
  end

  // Overrun pulse, one cycle after the losing push
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ovr_ff <= 1'b0;
    end else begin
      ovr_ff <= q.push && full && !do_pop;
    end
  end

  assign q.overrun   = ovr_ff;
  assign q.not_empty = (cnt_ff != IDX_ZERO);
  assign q.head_data = mem_ff[rd_ff][7:0];
  assign q.head_par  = mem_ff[rd_ff][8];
  assign q.head_frm  = mem_ff[rd_ff][9];
endmodule : rx_hold_buffer

/* rtl/serial_irq_ctrl.sv */
/*
  Interrupt vectoring, line status and receive error reporting for a
  dual-channel serial controller, reached over a byte-wide host bus with
  a control/data select. Assumes receivers, transmitters and the host bus
  run on clock_i; carrier detect, clear-to-send and the chain input are
  asynchronous pins and are synchronised here.
*/
module serial_irq_ctrl (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rstn_i,
  // Host bus
  input  wire logic                   bus_cs_i,
  input  wire logic                   bus_cd_i,
  input  wire logic                   bus_chan_b_i,
  input  wire logic                   bus_rd_i,
  input  wire logic                   bus_wr_i,
  input  wire logic [7:0]             bus_wdata_i,
  output logic      [7:0]             bus_rdata_o,
  // Receivers
  input  wire logic [ser_irq_pkg::NUM_CH-1:0] rx_valid_i,
  input  wire logic [7:0]             rx_data_i [ser_irq_pkg::NUM_CH],
  input  wire logic [ser_irq_pkg::NUM_CH-1:0] rx_frame_err_i,
  input  wire logic [ser_irq_pkg::NUM_CH-1:0] rx_parity_err_i,
  input  wire logic [ser_irq_pkg::NUM_CH-1:0] break_detect_i,
  // Transmitters
  input  wire logic [ser_irq_pkg::NUM_CH-1:0] tx_taken_i,
  output logic      [ser_irq_pkg::NUM_CH-1:0] tx_load_o,
  output logic      [7:0]             tx_data_o [ser_irq_pkg::NUM_CH],
  // Modem pins
  input  wire logic [ser_irq_pkg::NUM_CH-1:0] carrier_detect_status_i,
  input  wire logic [ser_irq_pkg::NUM_CH-1:0] clear_to_send_i,
  // Interrupt and daisy chain
  input  wire logic                   chain_priority_in_i,
  output logic                        chain_priority_out_o,
  output logic                        irq_req_o,
  output logic      [7:0]             vector_o
);
  import ser_irq_pkg::*;

  // ------------------------------------------------------------------
  // Per-channel state, each element driven by its own channel block, then shared vector and chain state
  // ------------------------------------------------------------------
  logic [PTR_W-1:0] ptr_ff     [NUM_CH];
  logic [7:0]       cfg_ff     [NUM_CH];
  logic [2:0]       snap_ff    [NUM_CH];
  logic [7:0]       rd_byte    [NUM_CH];
  logic [7:0]       head_byte  [NUM_CH];
  logic [3:0]       req        [NUM_CH];  // srx, rx, tx, ext
  logic [NUM_CH-1:0] vec_wr;
  logic [7:0]       vec_base_ff;
  logic [7:0]       mod_vec;
  logic [3:0]       pick;                 // any, code
  logic             chain_s1_ff;
  logic             chain_s2_ff;

  // Fixed-priority encoder over the eight sources
  function automatic logic [3:0] prio(input logic [3:0] a, input logic [3:0] b);
    if (a[3])      prio = {1'b1, VA_SRX};
    else if (a[2]) prio = {1'b1, VA_RX};
    else if (a[1]) prio = {1'b1, VA_TX};
    else if (a[0]) prio = {1'b1, VA_EXT};
    else if (b[3]) prio = {1'b1, VB_SRX};
    else if (b[2]) prio = {1'b1, VB_RX};
    else if (b[1]) prio = {1'b1, VB_TX};
    else if (b[0]) prio = {1'b1, VB_EXT};
    else           prio = {1'b0, VB_TX};
  endfunction : prio

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic CH_BIT = 1'(c);

    logic       sel;
    logic       ctl_wr;
    logic       ctl_rd;
    logic       dat_wr;
    logic       dat_rd;
    logic       cmd_wr;
    logic [2:0] cmd;
    logic       chan_rst;
    logic       rst_ext;
    logic       err_rst;
    logic       txp_rst;
    logic [1:0] rx_mode;
    logic       special;
    logic [2:0] cur;
    logic [1:0] dcd_s1_ff;
    logic [1:0] cts_s1_ff;
    logic       dcd_s2_ff;
    logic       cts_s2_ff;
    logic       ext_pend_ff;
    logic       tx_full_ff;
    logic       tx_pend_ff;
    logic       ovr_ff;
    logic       par_ff;
    logic       load_ff;
    logic [7:0] txd_ff;
    logic [7:0] line_status;
    logic [7:0] receive_error_status;

    rxq_if rxq ();

    rx_hold_buffer u_rxbuf (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .q       (rxq.buffer)
    );

    // ----------------------------------------------------------------
    // Bus decode for this channel
    // ----------------------------------------------------------------
    assign sel      = bus_cs_i && (bus_chan_b_i == CH_BIT);
    assign ctl_wr   = sel && bus_wr_i && bus_cd_i;
    assign ctl_rd   = sel && bus_rd_i && bus_cd_i;
    assign dat_wr   = sel && bus_wr_i && !bus_cd_i;
    assign dat_rd   = sel && bus_rd_i && !bus_cd_i;
    assign cmd_wr   = ctl_wr && (ptr_ff[c] == REG_CMD);
    assign cmd      = bus_wdata_i[CMD_MSB:CMD_LSB];
    assign chan_rst = cmd_wr && (cmd == CMD_CHAN_RST);
    assign rst_ext  = cmd_wr && (cmd == CMD_RST_EXT);
    assign err_rst  = cmd_wr && (cmd == CMD_ERR_RST);
    assign txp_rst  = cmd_wr && (cmd == CMD_RST_TXP);
    assign vec_wr[c] = ctl_wr && (ptr_ff[c] == REG_VEC);

    // Pointer: set by a command-register write, back to default after use
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        ptr_ff[c] <= REG_CMD;
      end else if (cmd_wr) begin
        ptr_ff[c] <= bus_wdata_i[PTR_W-1:0];
      end else if (ctl_wr || ctl_rd) begin
        ptr_ff[c] <= REG_CMD;
      end
    end

    // Interrupt configuration; zero at reset so nothing can interrupt
    always_ff @(posedge clock_i) begin
      if (!rstn_i || chan_rst) begin
        cfg_ff[c] <= RST_BYTE;
      end else if (ctl_wr && (ptr_ff[c] == REG_CFG)) begin
        cfg_ff[c] <= bus_wdata_i;
      end
    end

    // Three-stage synchronisers for the modem pins
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        dcd_s1_ff <= 2'h0;
        cts_s1_ff <= 2'h0;
        dcd_s2_ff <= 1'b0;
        cts_s2_ff <= 1'b0;
      end else begin
        dcd_s1_ff <= {dcd_s1_ff[0], carrier_detect_status_i[c]};
        cts_s1_ff <= {cts_s1_ff[0], clear_to_send_i[c]};
        dcd_s2_ff <= dcd_s1_ff[1];
        cts_s2_ff <= cts_s1_ff[1];
      end
    end

    // External/status: the snapshot freezes on a change until rearmed.
    // A change during a channel reset, or an external reset that rearms, is absorbed into the new snapshot.
    assign cur = {break_detect_i[c], cts_s2_ff, dcd_s2_ff};
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        snap_ff[c]  <= RST_PINS;
        ext_pend_ff <= 1'b0;
      end else begin
        if (!ext_pend_ff || rst_ext || chan_rst) begin
          snap_ff[c] <= cur;
        end
        if (chan_rst || (ext_pend_ff && rst_ext)) begin
          ext_pend_ff <= 1'b0;
        end else if (!ext_pend_ff && (cur != snap_ff[c])) begin
          ext_pend_ff <= 1'b1;
        end
      end
    end

    // Transmit buffer and its pending flag; a data write wins over a same-cycle take
    always_ff @(posedge clock_i) begin
      if (!rstn_i || chan_rst) begin
        tx_full_ff <= 1'b0;
        tx_pend_ff <= 1'b0;
      end else begin
        if (dat_wr) begin
          tx_full_ff <= 1'b1;
        end else if (tx_taken_i[c]) begin
          tx_full_ff <= 1'b0;
        end
        if (tx_taken_i[c] && tx_full_ff && !dat_wr) begin
          tx_pend_ff <= 1'b1;
        end else if (txp_rst || dat_wr) begin
          tx_pend_ff <= 1'b0;
        end
      end
    end

    // Transmit handoff, registered
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        load_ff <= 1'b0;
        txd_ff  <= RST_BYTE;
      end else begin
        load_ff <= dat_wr;
        if (dat_wr) begin
          txd_ff <= bus_wdata_i;
        end
      end
    end

    // Latched error flags; a new error beats a same-cycle error reset
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        ovr_ff <= 1'b0;
        par_ff <= 1'b0;
      end else begin
        if (rxq.overrun) begin
          ovr_ff <= 1'b1;
        end else if (err_rst || chan_rst) begin
          ovr_ff <= 1'b0;
        end
        if (rx_valid_i[c] && rx_parity_err_i[c]) begin
          par_ff <= 1'b1;
        end else if (err_rst || chan_rst) begin
          par_ff <= 1'b0;
        end
      end
    end

    // Receive buffer hookup; data reads pop regardless of error state
    assign rxq.push      = rx_valid_i[c];
    assign rxq.push_data = rx_data_i[c];
    assign rxq.push_frm  = rx_frame_err_i[c];
    assign rxq.push_par  = rx_parity_err_i[c];
    assign rxq.pop       = dat_rd;
    assign rxq.flush     = chan_rst;
    assign head_byte[c]  = rxq.head_data;

    // Status bytes
    always_comb begin
      line_status          = RST_BYTE;
      line_status[LS_RXAV] = rxq.not_empty;
      line_status[LS_TXE]  = !tx_full_ff;
      line_status[LS_DCD]  = snap_ff[c][0];
      line_status[LS_CTS]  = snap_ff[c][1];
      line_status[LS_BRK]  = snap_ff[c][2];
      receive_error_status         = RST_BYTE;
      receive_error_status[RE_PAR] = par_ff;
      receive_error_status[RE_OVR] = ovr_ff;
      receive_error_status[RE_FRM] = rxq.not_empty && rxq.head_frm;
    end

    // Control read mux by pointer
    always_comb begin
      if (ptr_ff[c] == REG_CMD) begin
        rd_byte[c] = line_status;
      end else if (ptr_ff[c] == REG_CFG) begin
        rd_byte[c] = receive_error_status;
      end else if (ptr_ff[c] == REG_VEC) begin
        rd_byte[c] = mod_vec;
      end else begin
        rd_byte[c] = RST_BYTE;
      end
    end

    // Source requests; special and plain receive are exclusive
    assign rx_mode = cfg_ff[c][CFG_RXM_MSB:CFG_RXM_LSB];
    assign special = rxq.head_frm || ovr_ff ||
                     (par_ff && (rx_mode != RXM_PAR_QUIET));
    assign req[c] = {rxq.not_empty && (rx_mode != RXM_OFF) && special,
                     rxq.not_empty && (rx_mode != RXM_OFF) && !special,
                     tx_pend_ff && cfg_ff[c][CFG_TX_EN],
                     ext_pend_ff && cfg_ff[c][CFG_EXT_EN]};

    assign tx_load_o[c] = load_ff;
    assign tx_data_o[c] = txd_ff;
  end

  // ------------------------------------------------------------------
  // Vector register, second channel only
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      vec_base_ff <= RST_BYTE;
    end else if (vec_wr[CH_B]) begin
      vec_base_ff <= bus_wdata_i;
    end
  end

  // Source code replaces bits 3..1 only; the rest pass through
  assign pick = prio(req[CH_A], req[CH_B]);
  always_comb begin
    mod_vec = vec_base_ff;
    if (cfg_ff[CH_B][CFG_SAV] && pick[3]) begin
      mod_vec[VEC_MSB:VEC_LSB] = pick[2:0];
    end
  end

  // ------------------------------------------------------------------
  // Host read data, registered one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      bus_rdata_o <= RST_BYTE;
    end else if (bus_cs_i && bus_rd_i) begin
      if (bus_cd_i) begin
        bus_rdata_o <= bus_chan_b_i ? rd_byte[CH_B] : rd_byte[CH_A];
      end else begin
        bus_rdata_o <= bus_chan_b_i ? head_byte[CH_B] : head_byte[CH_A];
      end
    end
  end

  // ------------------------------------------------------------------
  // Daisy chain and interrupt request; chain input is asynchronous
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      chain_s1_ff          <= 1'b0;
      chain_s2_ff          <= 1'b0;
      irq_req_o            <= 1'b0;
      chain_priority_out_o <= 1'b0;
      vector_o             <= RST_BYTE;
    end else begin
      chain_s1_ff          <= chain_priority_in_i;
      chain_s2_ff          <= chain_s1_ff;
      irq_req_o            <= chain_s2_ff && pick[3];
      chain_priority_out_o <= chain_s2_ff && !pick[3];
      vector_o             <= mod_vec;
    end
  end
endmodule : serial_irq_ctrl

/* tb/ser_irq_monitor.sv */
/* Port checker for serial_irq_ctrl.
   Assumes it is bound into the controller and runs on one clock. */
module ser_irq_monitor (
  // Clock, reset, host bus
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       bus_cs_i,
  input wire logic       bus_cd_i,
  input wire logic       bus_chan_b_i,
  input wire logic       bus_rd_i,
  input wire logic       bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  // Outputs watched
  input wire logic [1:0] tx_load_o,
  input wire logic [7:0] tx_data_o [2],
  input wire logic       chain_priority_in_i,
  input wire logic       chain_priority_out_o,
  input wire logic       irq_req_o,
  input wire logic [7:0] vector_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ser_irq_pkg::*;
  // Decoded host cycles
  wire logic wr_a  = bus_cs_i && bus_wr_i && !bus_cd_i && !bus_chan_b_i;
  wire logic wr_b  = bus_cs_i && bus_wr_i && !bus_cd_i && bus_chan_b_i;
  wire logic ctl_b = bus_cs_i && bus_wr_i && bus_cd_i && bus_chan_b_i;
  wire logic rd_on = bus_cs_i && bus_rd_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  tx_pulse_a: assert property (wr_a |=> tx_load_o[CH_A])
    else $error("no load pulse after data write");
  tx_byte_a: assert property (wr_a |=> tx_data_o[CH_A] == $past(bus_wdata_i))
    else $error("transmit byte differs from written byte");
  tx_cause_a: assert property (tx_load_o[CH_B] |-> $past(wr_b))
    else $error("load pulse without data write");
  chain_excl_a: assert property (irq_req_o |-> !chain_priority_out_o)
    else $error("request and chain pass both high");
  chain_gate_a: assert property (!chain_priority_in_i [*4] |->
    !irq_req_o && !chain_priority_out_o)
    else $error("request while chain input low");
  quiet_start_a: assert property ($rose(rstn_i) |-> !irq_req_o [*3])
    else $error("request before any config write");
  // Vector base changes only through a control write on the second channel
  vec_keep_a: assert property (!$past(ctl_b) && !$past(ctl_b, 2) |->
    $stable({vector_o[7:4], vector_o[0]}))
    else $error("fixed vector bits changed");
  rdata_hold_a: assert property (!$past(rd_on) && !$past(rd_on, 2) |->
    $stable(bus_rdata_o))
    else $error("read data moved without a read");
  cover property (irq_req_o && vector_o[3:1] == VA_EXT);
  cover property (irq_req_o && vector_o[3:1] == VB_SRX);
  cover property (tx_load_o[CH_A]);
endmodule : ser_irq_monitor

bind serial_irq_ctrl ser_irq_monitor i_mon (.clock_i, .rstn_i, .bus_cs_i, .bus_cd_i,
  .bus_chan_b_i, .bus_rd_i, .bus_wr_i, .bus_wdata_i, .bus_rdata_o, .tx_load_o, .tx_data_o,
  .chain_priority_in_i, .chain_priority_out_o, .irq_req_o, .vector_o);

/* tb/host_bus_model.sv */
/* Host CPU model for the byte-wide control/data bus.
   Assumes registered read data settles by the falling edge after the read edge. */
module host_bus_model (
  // Clock and read data
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  // Bus drive
  output logic            cs_o,
  output logic            cd_o,
  output logic            chb_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial {cs_o, cd_o, chb_o, rd_o, wr_o, wdata_o} = 13'h0;
  // One access; strobes stand across one rising edge, then drop
  task automatic access(input logic chb, cd, rd, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock_i);
    {cs_o, chb_o, cd_o, rd_o, wr_o, wdata_o} = {1'b1, chb, cd, rd, !rd, d};
    @(negedge clock_i);
    q = rdata_i;
    {cs_o, rd_o, wr_o} = 3'h0;
    wdata_o = ~d;  // Released bus shows no stale byte
  endtask : access
  // Pointer first, then the pointed register
  task automatic wreg(input logic chb, input logic [2:0] p, input logic [7:0] d);
    logic [7:0] q;
    access(chb, 1'b1, 1'b0, {5'h0, p}, q);
    access(chb, 1'b1, 1'b0, d, q);
  endtask : wreg
  task automatic rreg(input logic chb, input logic [2:0] p, output logic [7:0] q);
    access(chb, 1'b1, 1'b0, {5'h0, p}, q);
    access(chb, 1'b1, 1'b1, 8'h00, q);
  endtask : rreg
endmodule : host_bus_model

/* tb/tb.sv */
/* Self-checking bench for serial_irq_ctrl.
   Assumes the host model above; break and clear-to-send stay low. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ser_irq_pkg::*;
  localparam logic [7:0] BASE = 8'hf1;
  logic       clock_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       cs, cd, chb, rd, wr, chain_in, chain_out, irq;
  logic [7:0] wdata, rdata, vec, q;
  logic [7:0] rx_data [2];
  logic [7:0] tx_data [2];
  logic [1:0] rx_valid = 2'h0, rx_frm = 2'h0, rx_par = 2'h0, tx_taken = 2'h0, dcd = 2'h0;
  logic [1:0] tx_load;
  int         n_fail = 0;
  int         comparisons = 0;
  always #12.5 clock_i = ~clock_i;
  host_bus_model i_host (.clock_i, .rdata_i(rdata), .cs_o(cs), .cd_o(cd), .chb_o(chb),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
  serial_irq_ctrl i_dut (.clock_i, .rstn_i, .bus_cs_i(cs), .bus_cd_i(cd), .bus_chan_b_i(chb),
    .bus_rd_i(rd), .bus_wr_i(wr), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_frame_err_i(rx_frm),
    .rx_parity_err_i(rx_par), .break_detect_i(2'h0), .tx_taken_i(tx_taken),
    .tx_load_o(tx_load), .tx_data_o(tx_data), .carrier_detect_status_i(dcd),
    .clear_to_send_i(2'h0), .chain_priority_in_i(chain_in),
    .chain_priority_out_o(chain_out), .irq_req_o(irq), .vector_o(vec));
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] v(input logic [2:0] c);
    return {BASE[7:4], c, BASE[0]};
  endfunction : v
  // Sync and registered request paths need a few cycles to land
  task automatic settle;
    repeat (8) @(negedge clock_i);
  endtask : settle
  task automatic push(input int ch, input logic [7:0] d, input logic f, p);
    @(negedge clock_i);
    rx_valid[ch] = 1'b1;
    rx_data[ch] = d;
    {rx_frm[ch], rx_par[ch]} = {f, p};
    @(negedge clock_i);
    rx_valid[ch] = 1'b0;
  endtask : push
  task automatic t_setup;
    i_host.wreg(1'b1, REG_VEC, BASE);
    i_host.access(1'b0, 1'b1, 1'b0, 8'h10, q);
    i_host.access(1'b1, 1'b1, 1'b0, 8'h10, q);
    i_host.wreg(1'b1, REG_CFG, 8'h17);
    i_host.wreg(1'b0, REG_CFG, 8'h13);
    settle;
    check("idle irq", {7'h0, irq}, 8'h00);
    check("idle chain", {7'h0, chain_out}, 8'h01);
    i_host.rreg(1'b1, REG_VEC, q);
    check("readback", q, BASE);
    i_host.access(1'b0, 1'b1, 1'b1, 8'h00, q);
    check("status", q, 8'h04);
  endtask : t_setup
  task automatic t_srx;
    push(0, 8'ha5, 1'b0, 1'b1);
    settle;
    check("vector srx", vec, v(VA_SRX));
    i_host.rreg(1'b0, REG_VEC, q);
    check("readback srx", q, v(VA_SRX));
    i_host.rreg(1'b0, REG_CFG, q);
    check("error", q, 8'h10);
    i_host.access(1'b0, 1'b0, 1'b1, 8'h00, q);
    check("data", q, 8'ha5);
    i_host.rreg(1'b0, REG_CFG, q);
    check("parity kept", q, 8'h10);
    i_host.access(1'b0, 1'b1, 1'b0, 8'h30, q);
    i_host.rreg(1'b0, REG_CFG, q);
    check("error reset", q, 8'h00);
  endtask : t_srx
  task automatic t_prio;
    push(1, 8'h3c, 1'b0, 1'b0);
    settle;
    check("vector b rx", vec, v(VB_RX));
    dcd[0] = 1'b1;
    settle;
    check("vector ext", vec, v(VA_EXT));
    dcd[0] = 1'b0;  // Pin drops again; the snapshot must hold the change
    settle;
    i_host.access(1'b0, 1'b1, 1'b1, 8'h00, q);
    check("latched", q, 8'h0c);
    i_host.access(1'b0, 1'b1, 1'b0, 8'h10, q);
    settle;
    i_host.access(1'b0, 1'b1, 1'b1, 8'h00, q);
    check("follow", q, 8'h04);
    check("vector rearm", vec, v(VB_RX));
    i_host.access(1'b1, 1'b0, 1'b1, 8'h00, q);
    check("data b", q, 8'h3c);
  endtask : t_prio
  task automatic t_tx;
    i_host.access(1'b0, 1'b0, 1'b0, 8'h55, q);
    i_host.access(1'b0, 1'b1, 1'b1, 8'h00, q);
    check("tx full", q, 8'h00);
    tx_taken[0] = 1'b1;
    @(negedge clock_i);
    tx_taken[0] = 1'b0;
    settle;
    check("vector tx", vec, v(VA_TX));
    i_host.access(1'b0, 1'b1, 1'b0, 8'h28, q);
    settle;
    check("vector base", vec, BASE);
  endtask : t_tx
  task automatic t_overrun;
    push(1, 8'h01, 1'b1, 1'b0);
    for (int i = 2; i < 5; i++) push(1, 8'(i), 1'b0, 1'b0);
    settle;
    check("vector b srx", vec, v(VB_SRX));
    i_host.rreg(1'b1, REG_CFG, q);
    check("overrun", q, 8'h60);
    // The losing fourth byte replaced the newest one
    for (int i = 0; i < 3; i++) begin
      i_host.access(1'b1, 1'b0, 1'b1, 8'h00, q);
      check("data ovr", q, (i == 2) ? 8'h04 : 8'(i + 1));
    end
    i_host.access(1'b1, 1'b1, 1'b0, 8'h30, q);
  endtask : t_overrun
  task automatic t_quiet;
    i_host.wreg(1'b0, REG_CFG, 8'h1b);
    chain_in = 1'b0;
    push(0, 8'h11, 1'b0, 1'b1);
    settle;
    check("chain blocks", {6'h0, irq, chain_out}, 8'h00);
    chain_in = 1'b1;
    settle;
    check("vector quiet", vec, v(VA_RX));
    check("chain irq", {7'h0, irq}, 8'h01);
    // Channel reset clears the config, so the request must go away
    i_host.access(1'b0, 1'b1, 1'b0, 8'h18, q);
    settle;
    check("reset quiet", {7'h0, irq}, 8'h00);
  endtask : t_quiet
  task automatic tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Main sequence after four reset cycles
  initial begin
    chain_in = 1'b1;
    rx_data = '{8'h00, 8'h00};
    repeat (4) @(negedge clock_i);
    rstn_i = 1'b1;
    t_setup;
    t_srx;
    t_prio;
    t_tx;
    t_overrun;
    t_quiet;
    tally_and_finish;
  end
  // Watchdog well beyond the roughly 190 cycles the tests need
  initial begin
    #50000;
    n_fail++;
    tally_and_finish;
  end
endmodule : tb
